// File: inc/flash_seq_defs.vh
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_T_PROGRAM_STROBE     12'h008
`define ADDR_T_ERASE    12'h00C
`define ADDR_T_MASS     12'h010
`define ADDR_T_NVS      12'h014
`define ADDR_T_NVH      12'h018
`define ADDR_T_NVH_BULK 12'h01C
`define ADDR_T_PGS      12'h020
`define ADDR_T_RCV      12'h024
`define ADDR_HV_USED    12'h028
`define ADDR_ADDR       12'h02C
`define ADDR_DATA       12'h030
`define ADDR_RDATA      12'h034

// ----------------------------------------------------------------
// Control field layout (write 1 to start)
// ----------------------------------------------------------------
`define CTRL_OP_LO      0
`define CTRL_OP_HI      2
`define CTRL_INFO_BIT   3
`define CTRL_MANUAL_BIT 4
`define CTRL_START_BIT  8
`define CTRL_HVCLR_BIT  9

// Operation codes
`define OP_READ         3'h1
`define OP_PROGRAM_STROBE         3'h2
`define OP_PAGE_ERASE   3'h3
`define OP_MASS_ERASE   3'h4

// ----------------------------------------------------------------
// Timing figures, in ns, and system clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   40
`define T_PROGRAM_STROBE_NS       20000
`define T_ERASE_NS      20000000
`define T_MASS_NS       100000000
`define T_NVS_NS        5000
`define T_NVH_NS        5000
`define T_NVH_BULK_NS   100000
`define T_PGS_NS        10000
`define T_RCV_NS        1000
`define T_HV_NS         3000000

// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/interval_timer.v
`timescale 1ns/1ps
`include "flash_seq_defs.vh"

// Down counter: loaded on i_load, raises o_done when it reaches zero
module interval_timer #(
    parameter W = 32
) (
    input  wire         i_clk,     // System clock
    input  wire         i_sys_rst, // Async reset, active high
    input  wire         i_load,    // Load a new interval
    input  wire [W-1:0] i_count,   // Interval length in cycles
    output wire         o_done     // Count expired (level)
);
    reg [W-1:0] cnt_reg;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // A count of zero behaves as one cycle, so no phase is skipped
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= {W{1'b0}};
        end else if (i_load) begin
            cnt_reg <= (i_count == {W{1'b0}}) ? {W{1'b0}}
                                              : i_count - 1'b1;
        end else if (cnt_reg != {W{1'b0}}) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign o_done = (cnt_reg == {W{1'b0}}) && !i_load;
endmodule // interval_timer

// File: rtl/flash_array_control_sequencer.v
`timescale 1ns/1ps
`include "flash_seq_defs.vh"

// Summary of operation
// - Standby drives every array strobe low, row enable included.
// - Column enable high only for read and word program.
// - Read: row, column, sense amp and output enables high; rest low.
// - Output enable high only in read mode.
// - Program: row, column, program and store strobes high.
// - Page erase: row, erase and store strobes high.
// - Mass erase: page erase encoding plus mass erase strobe.
// - Block select picks info block; mass erase then clears both.
// - Store strobe rises set-up time after erase strobe; for program it rises first.
// - Store stays high hold time after program or erase drops.
// - After mass erase, store stays high the bulk hold time.
// - Program strobe waits program set-up time after store rises.
// - Cumulative high voltage time per row limited to 3 ms; code keeps one budget for all rows, zeroed by any erase or an HVCLR write.
// - Smart mode: hold, set-up and hold each at least a cycle.
// - Manual intervals enforced only in manual programming mode.
// - Software-writable duration registers for each interval.
module flash_array_control_sequencer #(
    parameter TW = 32
) (
    input  wire        i_clk,              // System clock, 25 MHz
    input  wire        i_sys_rst,          // Async reset, active high
    input  wire        i_psel,             // APB select
    input  wire        i_penable,          // APB enable
    input  wire        i_pwrite,           // APB write
    input  wire [11:0] i_paddr,            // APB byte address
    input  wire [31:0] i_pwdata,           // APB write data
    output reg  [31:0] o_prdata,           // APB read data
    output reg         o_pready,           // APB ready
    output reg         o_pslverr,          // APB error
    input  wire [15:0] i_array_dout,       // Array data out
    output reg         o_row_enable,       // Row enable
    output reg         o_column_enable,    // Column enable
    output reg         o_sense_amp_enable, // Sense amplifier enable
    output reg         o_output_enable,    // Array output enable
    output reg         o_program_strobe,   // Program strobe
    output reg         o_erase_strobe,     // Erase strobe
    output reg         o_mass_erase_strobe,// Mass erase strobe
    output reg         o_store_strobe,     // Non-volatile store strobe
    output reg         o_info_block_select,// Information block select
    output reg  [15:0] o_array_addr,       // Array address
    output reg  [15:0] o_array_din         // Array write data
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_RSET  = 4'h1; // Read: enables up
    localparam [3:0] S_RCAP  = 4'h2; // Read: capture data
    localparam [3:0] S_SETUP = 4'h3; // Row/column up, strobe set-up
    localparam [3:0] S_NVS   = 4'h4; // Erase up, wait before store
    localparam [3:0] S_PGS   = 4'h5; // Store up, wait before program
    localparam [3:0] S_HV    = 4'h6; // High voltage pulse
    localparam [3:0] S_NVH   = 4'h7; // Strobe down, store held
    localparam [3:0] S_RCV   = 4'h8; // Store down, recovery
    localparam [3:0] S_ADH   = 4'h9; // Address/data hold

    localparam [TW-1:0] C_PROGRAM_STROBE  = `CYC_UP(`T_PROGRAM_STROBE_NS);
    localparam [TW-1:0] C_ERASE = `CYC_UP(`T_ERASE_NS);
    localparam [TW-1:0] C_MASS  = `CYC_UP(`T_MASS_NS);
    localparam [TW-1:0] C_NVS   = `CYC_UP(`T_NVS_NS);
    localparam [TW-1:0] C_NVH   = `CYC_UP(`T_NVH_NS);
    localparam [TW-1:0] C_NVHB  = `CYC_UP(`T_NVH_BULK_NS);
    localparam [TW-1:0] C_PGS   = `CYC_UP(`T_PGS_NS);
    localparam [TW-1:0] C_RCV   = `CYC_UP(`T_RCV_NS);
    localparam [TW-1:0] C_HV    = `T_HV_NS / `CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [3:0]    state_reg;
    reg [2:0]    op_reg;
    reg          info_reg;
    reg          manual_reg;
    reg          busy_reg;
    reg          hv_err_reg;
    reg          done_reg;
    reg [TW-1:0] t_program_strobe_reg;
    reg [TW-1:0] t_erase_reg;
    reg [TW-1:0] t_mass_reg;
    reg [TW-1:0] t_nvs_reg;
    reg [TW-1:0] t_nvh_reg;
    reg [TW-1:0] t_nvhb_reg;
    reg [TW-1:0] t_pgs_reg;
    reg [TW-1:0] t_rcv_reg;
    reg [TW-1:0] hv_used_reg;
    reg [15:0]   addr_reg;
    reg [15:0]   data_reg;
    reg [15:0]   rdata_reg;

    reg          tm_load;
    reg [TW-1:0] tm_count;
    wire         tm_done;

    wire wr_en  = i_psel && i_penable && i_pwrite && o_pready;
    wire acc_en = i_psel && i_penable && o_pready;
    wire start  = wr_en && (i_paddr == `ADDR_CTRL)
                  && i_pwdata[`CTRL_START_BIT] && !busy_reg;
    wire [2:0] new_op = i_pwdata[`CTRL_OP_HI:`CTRL_OP_LO];
    wire is_mass = (op_reg == `OP_MASS_ERASE);
    wire is_program_strobe = (op_reg == `OP_PROGRAM_STROBE);

    // A program pulse only starts while the row budget holds it
    wire hv_fits = ({1'b0, hv_used_reg} + {1'b0, t_program_strobe_reg}) <= {1'b0, C_HV};

    interval_timer #(
        .W (TW)
    ) u_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (tm_load),
        .i_count   (tm_count),
        .o_done    (tm_done)
    );

    // ------------------------------------------------------------
    // APB slave: no wait states; read data is registered in the setup phase
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h00000000;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_pslverr <= (i_paddr > `ADDR_RDATA) || (i_paddr[1:0] != 2'h0);
                case (i_paddr)
                    `ADDR_CTRL:       o_prdata <= {27'h0000000, manual_reg,
                                                   info_reg, op_reg};
                    `ADDR_STATUS:     o_prdata <= {24'h000000, state_reg,
                                                   1'b0, hv_err_reg,
                                                   done_reg, busy_reg};
                    `ADDR_T_PROGRAM_STROBE:     o_prdata <= t_program_strobe_reg;
                    `ADDR_T_ERASE:    o_prdata <= t_erase_reg;
                    `ADDR_T_MASS:     o_prdata <= t_mass_reg;
                    `ADDR_T_NVS:      o_prdata <= t_nvs_reg;
                    `ADDR_T_NVH:      o_prdata <= t_nvh_reg;
                    `ADDR_T_NVH_BULK: o_prdata <= t_nvhb_reg;
                    `ADDR_T_PGS:      o_prdata <= t_pgs_reg;
                    `ADDR_T_RCV:      o_prdata <= t_rcv_reg;
                    `ADDR_HV_USED:    o_prdata <= hv_used_reg;
                    `ADDR_ADDR:       o_prdata <= {16'h0000, addr_reg};
                    `ADDR_DATA:       o_prdata <= {16'h0000, data_reg};
                    `ADDR_RDATA:      o_prdata <= {16'h0000, rdata_reg};
                    default:          o_prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers; writes to timing are refused while busy
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            op_reg      <= 3'h0;
            info_reg    <= 1'b0;
            manual_reg  <= 1'b1;
            t_program_strobe_reg  <= C_PROGRAM_STROBE;
            t_erase_reg <= C_ERASE;
            t_mass_reg  <= C_MASS;
            t_nvs_reg   <= C_NVS;
            t_nvh_reg   <= C_NVH;
            t_nvhb_reg  <= C_NVHB;
            t_pgs_reg   <= C_PGS;
            t_rcv_reg   <= C_RCV;
            addr_reg    <= 16'h0000;
            data_reg    <= 16'h0000;
        end else if (wr_en && !busy_reg) begin
            case (i_paddr)
                `ADDR_CTRL: begin
                    op_reg     <= new_op;
                    info_reg   <= i_pwdata[`CTRL_INFO_BIT];
                    manual_reg <= i_pwdata[`CTRL_MANUAL_BIT];
                end
                // Program and erase durations never fall below the least figures
                `ADDR_T_PROGRAM_STROBE:  t_program_strobe_reg  <= (i_pwdata < C_PROGRAM_STROBE)
                                              ? C_PROGRAM_STROBE : i_pwdata;
                `ADDR_T_ERASE: t_erase_reg <= (i_pwdata < C_ERASE)
                                              ? C_ERASE : i_pwdata;
                `ADDR_T_MASS:  t_mass_reg  <= (i_pwdata < C_MASS)
                                              ? C_MASS : i_pwdata;
                `ADDR_T_NVS:      t_nvs_reg  <= i_pwdata;
                `ADDR_T_NVH:      t_nvh_reg  <= i_pwdata;
                `ADDR_T_NVH_BULK: t_nvhb_reg <= i_pwdata;
                `ADDR_T_PGS:      t_pgs_reg  <= i_pwdata;
                `ADDR_T_RCV:      t_rcv_reg  <= i_pwdata;
                `ADDR_ADDR:       addr_reg   <= i_pwdata[15:0];
                `ADDR_DATA:       data_reg   <= i_pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Outputs are registered; standby sets the full strobe pattern, other states only the strobes they move
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg           <= S_IDLE;
            busy_reg            <= 1'b0;
            done_reg            <= 1'b0;
            hv_err_reg          <= 1'b0;
            hv_used_reg         <= {TW{1'b0}};
            rdata_reg           <= 16'h0000;
            tm_load             <= 1'b0;
            tm_count            <= {TW{1'b0}};
            o_row_enable        <= 1'b0;
            o_column_enable     <= 1'b0;
            o_sense_amp_enable  <= 1'b0;
            o_output_enable     <= 1'b0;
            o_program_strobe    <= 1'b0;
            o_erase_strobe      <= 1'b0;
            o_mass_erase_strobe <= 1'b0;
            o_store_strobe      <= 1'b0;
            o_info_block_select <= 1'b0;
            o_array_addr        <= 16'h0000;
            o_array_din         <= 16'h0000;
        end else begin
            tm_load <= 1'b0;
            // Status write with busy bit clears done and error flags
            if (wr_en && i_paddr == `ADDR_STATUS && i_pwdata[0]) begin
                done_reg   <= 1'b0;
                hv_err_reg <= 1'b0;
            end
            if (wr_en && i_paddr == `ADDR_CTRL && i_pwdata[`CTRL_HVCLR_BIT])
                hv_used_reg <= {TW{1'b0}};
            case (state_reg)
                S_IDLE: begin
                    // Standby: every strobe low
                    o_row_enable        <= 1'b0;
                    o_column_enable     <= 1'b0;
                    o_sense_amp_enable  <= 1'b0;
                    o_output_enable     <= 1'b0;
                    o_program_strobe    <= 1'b0;
                    o_erase_strobe      <= 1'b0;
                    o_mass_erase_strobe <= 1'b0;
                    o_store_strobe      <= 1'b0;
                    busy_reg            <= 1'b0;
                    if (start) begin
                        busy_reg            <= 1'b1;
                        o_info_block_select <= i_pwdata[`CTRL_INFO_BIT];
                        o_array_addr        <= addr_reg;
                        o_array_din         <= data_reg;
                        if (new_op == `OP_READ) begin
                            state_reg <= S_RSET;
                        end else if (new_op == `OP_PROGRAM_STROBE
                                  || new_op == `OP_PAGE_ERASE
                                  || new_op == `OP_MASS_ERASE) begin
                            state_reg <= S_SETUP; // Address set-up
                        end else begin
                            busy_reg <= 1'b0;
                        end
                    end
                end
                S_RSET: begin
                    // Read pattern
                    o_row_enable       <= 1'b1;
                    o_column_enable    <= 1'b1;
                    o_sense_amp_enable <= 1'b1;
                    o_output_enable    <= 1'b1;
                    state_reg          <= S_RCAP;
                end
                S_RCAP: begin
                    rdata_reg <= i_array_dout;
                    done_reg  <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_SETUP: begin
                    // Program whose pulse would overrun the row budget is refused
                    if (is_program_strobe && !hv_fits) begin
                        hv_err_reg <= 1'b1;
                        state_reg  <= S_IDLE;
                    end else begin
                        o_row_enable    <= 1'b1;
                        o_column_enable <= is_program_strobe;
                        tm_load         <= 1'b1;
                        if (is_program_strobe) begin
                            // Store first, program later
                            o_store_strobe <= 1'b1;
                            tm_count  <= manual_reg ? t_pgs_reg : 1;
                            state_reg <= S_PGS;
                        end else begin
                            o_erase_strobe      <= 1'b1;
                            o_mass_erase_strobe <= is_mass;
                            tm_count  <= manual_reg ? t_nvs_reg : 1;
                            state_reg <= S_NVS;
                        end
                    end
                end
                S_NVS: begin
                    // Store rises after the set-up count
                    if (tm_done && !tm_load) begin
                        o_store_strobe <= 1'b1;
                        tm_load        <= 1'b1;
                        tm_count       <= is_mass ? t_mass_reg : t_erase_reg;
                        state_reg      <= S_HV;
                    end
                end
                S_PGS: begin
                    if (tm_done && !tm_load) begin
                        o_program_strobe <= 1'b1;
                        tm_load          <= 1'b1;
                        tm_count         <= t_program_strobe_reg;
                        hv_used_reg      <= hv_used_reg + t_program_strobe_reg;
                        state_reg        <= S_HV;
                    end
                end
                S_HV: begin
                    if (tm_done && !tm_load) begin
                        o_program_strobe    <= 1'b0;
                        o_erase_strobe      <= 1'b0;
                        o_mass_erase_strobe <= 1'b0;
                        tm_load             <= 1'b1;
                        // Hold store after the strobe drops
                        if (!manual_reg)
                            tm_count <= 1;
                        else
                            tm_count <= is_mass ? t_nvhb_reg : t_nvh_reg;
                        // An erase restores the row budget
                        if (!is_program_strobe)
                            hv_used_reg <= {TW{1'b0}};
                        state_reg <= S_NVH;
                    end
                end
                S_NVH: begin
                    if (tm_done && !tm_load) begin
                        o_store_strobe <= 1'b0;
                        tm_load        <= 1'b1;
                        tm_count       <= manual_reg ? t_rcv_reg : 1;
                        state_reg      <= S_RCV;
                    end
                end
                S_RCV: begin
                    if (tm_done && !tm_load) begin
                        o_row_enable    <= 1'b0;
                        o_column_enable <= 1'b0;
                        state_reg       <= S_ADH;
                    end
                end
                S_ADH: begin
                    // Address and data held one more cycle
                    done_reg  <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // flash_array_control_sequencer

// File: sim/flash_array_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Array macro model
// ----------------------------------------------------------------
module flash_array_model (
    input  wire        i_clk,           // System clock
    input  wire        i_output_enable, // Output enable
    input  wire [15:0] i_array_addr,    // Word address
    output wire [15:0] o_array_dout     // Data out
);
    reg flip = 1'b0;
    // A released bus must not look stable, so it changes every cycle
    always @(posedge i_clk) begin
        flip <= ~flip;
    end
    assign o_array_dout = i_output_enable ? ~i_array_addr
                                          : {16{flip}} ^ 16'h5A5A;
endmodule // flash_array_model

// File: sim/flash_seq_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Strobe encoding and interval checker
// ----------------------------------------------------------------
module flash_seq_checker (
    input logic i_clk,               // System clock
    input logic i_sys_rst,           // Async reset
    input logic o_row_enable,        // Row enable
    input logic o_column_enable,     // Column enable
    input logic o_sense_amp_enable,  // Sense amp enable
    input logic o_output_enable,     // Output enable
    input logic o_program_strobe,    // Program strobe
    input logic o_erase_strobe,      // Erase strobe
    input logic o_mass_erase_strobe, // Mass erase strobe
    input logic o_store_strobe       // Store strobe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [15:0] st_cnt, pg_cnt, er_cnt, rel_cnt;
    wire  [7:0]  strb = {o_row_enable, o_column_enable, o_sense_amp_enable,
                         o_output_enable, o_program_strobe, o_erase_strobe,
                         o_mass_erase_strobe, o_store_strobe};
    function automatic logic [15:0] inc(input logic [15:0] x);
        return x + (x != 16'hFFFF);
    endfunction
    // Phase run lengths; saturating so a long erase cannot wrap
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_cnt  <= 16'h0000;
            pg_cnt  <= 16'h0000;
            er_cnt  <= 16'h0000;
            rel_cnt <= 16'h0000;
        end else begin
            st_cnt  <= o_store_strobe ? inc(st_cnt) : 16'h0000;
            pg_cnt  <= o_program_strobe ? inc(pg_cnt) : 16'h0000;
            er_cnt  <= o_erase_strobe ? inc(er_cnt) : 16'h0000;
            rel_cnt <= (o_store_strobe && !o_program_strobe &&
                        !o_erase_strobe) ? inc(rel_cnt) : 16'h0000;
        end
    end
    property p_standby; !o_row_enable |-> strb == 8'h00; endproperty
    a_standby: assert property (p_standby) else $error("standby");
    property p_col; o_column_enable |-> !o_erase_strobe; endproperty
    a_col: assert property (p_col) else $error("column in erase");
    property p_read; o_output_enable |-> strb == 8'hF0; endproperty
    a_read: assert property (p_read) else $error("read code");
    property p_program_strobe; o_program_strobe |-> strb == 8'hC9; endproperty
    a_program_strobe: assert property (p_program_strobe) else $error("program code");
    property p_erase; o_erase_strobe |-> (strb & 8'hFC) == 8'h84; endproperty
    a_erase: assert property (p_erase) else $error("erase code");
    property p_mass;
        o_mass_erase_strobe |-> o_row_enable && !o_column_enable;
    endproperty
    a_mass: assert property (p_mass) else $error("mass code");
    property p_nvs;
        $rose(o_store_strobe) && o_erase_strobe |-> er_cnt >= 16'h007D;
    endproperty
    a_nvs: assert property (p_nvs) else $error("store setup");
    property p_nvh; $fell(o_store_strobe) |-> rel_cnt >= 16'h007D; endproperty
    a_nvh: assert property (p_nvh) else $error("store hold");
    property p_pgs; $rose(o_program_strobe) |-> st_cnt >= 16'h00FA; endproperty
    a_pgs: assert property (p_pgs) else $error("program setup");
    property p_tprog;
        $fell(o_program_strobe) |-> pg_cnt >= 16'h01F4;
    endproperty
    a_tprog: assert property (p_tprog) else $error("program time");
endmodule // flash_seq_checker
bind flash_array_control_sequencer flash_seq_checker u_flash_seq_checker (
    .i_clk, .i_sys_rst, .o_row_enable, .o_column_enable,
    .o_sense_amp_enable, .o_output_enable, .o_program_strobe,
    .o_erase_strobe, .o_mass_erase_strobe, .o_store_strobe);

// File: sim/flash_array_control_sequencer_bench.sv
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
// ----------------------------------------------------------------
// Sequencer bench
// ----------------------------------------------------------------
module flash_array_control_sequencer_bench;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h00000000, rd;
    logic        er;
    wire  [31:0] o_prdata;
    wire  [15:0] i_array_dout, o_array_addr, o_array_din;
    wire         o_pready, o_pslverr, o_row_enable, o_column_enable;
    wire         o_sense_amp_enable, o_output_enable, o_program_strobe;
    wire         o_erase_strobe, o_mass_erase_strobe, o_store_strobe;
    wire         o_info_block_select;
    wire  [7:0]  strb = {o_row_enable, o_column_enable, o_sense_amp_enable,
                         o_output_enable, o_program_strobe, o_erase_strobe,
                         o_mass_erase_strobe, o_store_strobe};
    int          num_errors = 0, checks = 0;
    flash_array_control_sequencer u_flash_array_control_sequencer (.i_clk,
        .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_array_dout, .o_row_enable,
        .o_column_enable, .o_sense_amp_enable, .o_output_enable,
        .o_program_strobe, .o_erase_strobe, .o_mass_erase_strobe,
        .o_store_strobe, .o_info_block_select, .o_array_addr, .o_array_din);
    flash_array_model u_flash_array_model (.i_clk,
        .i_output_enable(o_output_enable), .i_array_addr(o_array_addr),
        .o_array_dout(i_array_dout));
    always #20 i_clk = ~i_clk;
    task chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task wt(input int b, input logic v);
        do @(posedge i_clk); while (strb[b] !== v);
    endtask
    task t_regs;
        chk("idle strobes", 32'h00000000, strb);
        apb(1'b0, `ADDR_T_PROGRAM_STROBE, 32'h00000000);
        chk("program time", 32'h000001F4, rd);
        apb(1'b0, `ADDR_T_NVS, 32'h00000000);
        chk("store setup", 32'h0000007D, rd);
        apb(1'b0, 12'h03C, 32'h00000000);
        chk("unmapped error", 32'h00000001, er);
    endtask
    task t_read;
        apb(1'b1, `ADDR_ADDR, 32'h00000012);
        apb(1'b1, `ADDR_CTRL, 32'h00000109);
        wt(4, 1'b1);
        chk("read strobes", 32'h000000F0, strb);
        chk("read block", 32'h00000001, o_info_block_select);
        wt(4, 1'b0);
        apb(1'b0, `ADDR_RDATA, 32'h00000000);
        chk("read data", 32'h0000FFED, rd[15:0]);
    endtask
    task t_program_strobe;
        apb(1'b1, `ADDR_ADDR, 32'h00000040);
        apb(1'b1, `ADDR_DATA, 32'h0000A5C3);
        apb(1'b1, `ADDR_CTRL, 32'h00000112);
        wt(3, 1'b1);
        chk("program strobes", 32'h000000C9, strb);
        chk("program block", 32'h00000000, o_info_block_select);
        chk("program data", 32'h0000A5C3, o_array_din);
        wt(7, 1'b0);
        chk("after program", 32'h00000000, strb);
    endtask
    // Erases run far too long here, so each is cut by a reset
    task t_erase(input logic [2:0] op, input logic info);
        apb(1'b1, `ADDR_T_RCV, 32'h0000001E);
        apb(1'b1, `ADDR_CTRL, 32'h00000110 | {28'h0000000, info, op});
        apb(1'b1, `ADDR_T_RCV, 32'h00000063);
        apb(1'b0, `ADDR_T_RCV, 32'h00000000);
        chk("busy write", 32'h0000001E, rd);
        wt(0, 1'b1);
        chk("erase strobes", (op == `OP_MASS_ERASE) ? 32'h00000087
                                                    : 32'h00000085, strb);
        chk("erase block", {31'h00000000, info}, o_info_block_select);
        i_sys_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk("reset strobes", 32'h00000000, strb);
        i_sys_rst <= 1'b0;
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_regs;
        t_read;
        t_program_strobe;
        for (int i = 0; i < 4; i++) begin
            t_erase((i < 2) ? `OP_PAGE_ERASE : `OP_MASS_ERASE, i[0]);
        end
        test_done;
    end
    // Watchdog well past the under two thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        test_done;
    end
endmodule // flash_array_control_sequencer_bench
